// file: verilog/aad_decoder.sv
/*
 aad_decoder: action store, hit counters and decoder for the two
 second-stage classifier lookups, with an apb register slave.
 assumes: frame requests come from logic on i_clk, one per cycle at
 most; the apb master follows the standard setup/access sequence.
*/
// Summary of operation
// - each frame yields its own action vector from each lookup.
// - misses use a per-port default first, one shared default second.
// - default vectors decode exactly like matched vectors.
// - single copy goes to cpu only while the hit counter is zero.
// - copy-to-cpu copies every hitting frame to the selected queue.
// - three-bit queue select picks the cpu queue for both copy kinds.
// - port-set mode: none, and, replace dmac result, replace all.
// - cpu port membership passes through untouched by port-set mode.
// - mirror enable also sends the frame to the mirror target ports.
// - learning disable suppresses source learning for hitting frames.
// - policer enable works only in first-lookup actions.
// - policer-only bypasses qos and port policers.
// - eleven-bit port set at bit 22 feeds the port-set mode.
// - nine-bit rewrite command passes on; low nibble zero is no-op.
// - low nibble 8 swaps macs and clears source bit 40.
// - low three bits 2 select one-step timing mode.
// - one-step: bit 7 add/subtract, bit 5 add egress delay.
// - one-step bits 4:3 pick ingress delay, not on backplane ports.
// - low three bits 3 select two-step with id in bits 8:3.
// - code 9 selects origin timestamp mode.
// - each action has a 32-bit hit counter bumped on every hit.
// - combined mirror request is the or of both lookups.
module aad_decoder #(
   parameter int ENTRIES = aad_pkg::ENTRIES
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // lookup results
   input wire aad_pkg::aad_frame_t i_frm,
   // decoded commands
   output aad_pkg::aad_dec_t o_dec
);
   localparam int NACT = ENTRIES + aad_pkg::PORTS + 1;
   localparam int IW = aad_pkg::IDX_W;
   localparam int AW = aad_pkg::ACT_W;
   localparam int CW = aad_pkg::CNT_W;
   localparam int NP = aad_pkg::PORTS;

   // ---------------------------------------------
   // storage
   // ---------------------------------------------
   logic [AW-1:0] act_reg [NACT];
   logic [CW-1:0] cnt_reg [NACT];
   logic [IW-1:0] sel_reg;
   logic [NP-1:0] mirr_reg;
   logic pready_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;

   // ---------------------------------------------
   // apb decode
   // ---------------------------------------------
   logic acc;
   logic wr_en;
   logic sel_ok;
   logic [31:0] rd_data;
   logic rd_err;
   logic [AW-1:0] sel_act;
   logic [CW-1:0] sel_cnt;

   // one wait state so read data leaves a flop
   assign acc = i_psel & i_penable;
   assign wr_en = acc & pready_reg & i_pwrite & ~pslverr_reg;
   assign sel_ok = (sel_reg < IW'(NACT));

   always_comb begin
      sel_act = aad_pkg::ACT_RST;
      sel_cnt = '0;
      if (sel_ok) begin
         sel_act = act_reg[sel_reg];
         sel_cnt = cnt_reg[sel_reg];
      end
   end

   always_comb begin
      rd_data = 32'h0;
      rd_err = 1'b0;
      case (i_paddr)
         aad_pkg::OFS_SEL: begin
            rd_data = {{(32 - IW){1'b0}}, sel_reg};
         end
         aad_pkg::OFS_LO: begin
            rd_data = sel_act[31:0];
         end
         aad_pkg::OFS_HI: begin
            rd_data = {{(64 - AW){1'b0}}, sel_act[AW-1:32]};
         end
         aad_pkg::OFS_CNT: begin
            rd_data = sel_cnt;
         end
         aad_pkg::OFS_MIRR: begin
            rd_data = {{(32 - NP){1'b0}}, mirr_reg};
         end
         default: begin
            rd_err = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pready_reg <= 1'b0;
         prdata_reg <= 32'h0;
         pslverr_reg <= 1'b0;
      end else if (acc && !pready_reg) begin
         pready_reg <= 1'b1;
         prdata_reg <= i_pwrite ? 32'h0 : rd_data;
         pslverr_reg <= rd_err;
      end else begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sel_reg <= '0;
      end else if (wr_en && i_paddr == aad_pkg::OFS_SEL) begin
         sel_reg <= i_pwdata[IW-1:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mirr_reg <= aad_pkg::MIRR_RST;
      end else if (wr_en && i_paddr == aad_pkg::OFS_MIRR) begin
         mirr_reg <= i_pwdata[NP-1:0];
      end
   end

   // ---------------------------------------------
   // lookup selection
   // ---------------------------------------------
   logic [IW-1:0] i1;
   logic [IW-1:0] i2;
   logic [AW-1:0] a1;
   logic [AW-1:0] a2;
   logic [CW-1:0] c1;

   // misses fall back to the default slots after the entries
   assign i1 = i_frm.hit1 ? i_frm.idx1 : IW'(ENTRIES + int'(i_frm.port));
   assign i2 = i_frm.hit2 ? i_frm.idx2 : IW'(ENTRIES + NP);

   // defaults read from the same store as matches
   always_comb begin
      a1 = aad_pkg::ACT_RST;
      a2 = aad_pkg::ACT_RST;
      c1 = '0;
      if (i1 < IW'(NACT)) begin
         a1 = act_reg[i1];
         c1 = cnt_reg[i1];
      end
      if (i2 < IW'(NACT)) begin
         a2 = act_reg[i2];
      end
   end

   logic [CW-1:0] c2;
   always_comb begin
      c2 = '0;
      if (i2 < IW'(NACT)) begin
         c2 = cnt_reg[i2];
      end
   end

   // ---------------------------------------------
   // per-entry store and hit counters
   // ---------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NACT; g++) begin : g_ent
         logic h1;
         logic h2;
         logic wsel;
         logic [CW-1:0] cbase;
         assign h1 = i_frm.valid & (i1 == IW'(g));
         assign h2 = i_frm.valid & (i2 == IW'(g));
         assign wsel = wr_en & (sel_reg == IW'(g));
         // a hit in the clearing cycle still counts
         assign cbase = (wsel && i_paddr == aad_pkg::OFS_CNT) ? i_pwdata : cnt_reg[g];

         always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               act_reg[g] <= aad_pkg::ACT_RST;
            end else if (wsel && i_paddr == aad_pkg::OFS_LO) begin
               act_reg[g][31:0] <= i_pwdata;
            end else if (wsel && i_paddr == aad_pkg::OFS_HI) begin
               act_reg[g][AW-1:32] <= i_pwdata[AW-33:0];
            end
         end

         always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               cnt_reg[g] <= '0;
            end else begin
               cnt_reg[g] <= cbase + CW'(h1) + CW'(h2);
            end
         end
      end
   endgenerate

   // ---------------------------------------------
   // decode
   // ---------------------------------------------
   function automatic logic [NP-1:0] apply_set(
      input logic [AW-1:0] a,
      input logic [NP-1:0] cur,
      input logic [NP-1:0] base
   );
      logic [NP-1:0] p;
      aad_pkg::aad_mode_t m;
      p = a[aad_pkg::PSET_POS +: NP];
      m = aad_pkg::aad_mode_t'(a[aad_pkg::MODE_POS +: aad_pkg::MODE_W]);
      case (m)
         aad_pkg::MM_NONE: apply_set = cur;
         aad_pkg::MM_AND: apply_set = cur & p;
         aad_pkg::MM_POLICY: apply_set = base & p;
         aad_pkg::MM_REDIR: apply_set = p;
         default: apply_set = cur;
      endcase
   endfunction

   logic cp1;
   logic cp2;
   logic [NP-1:0] set1;
   localparam int REW_W_L = aad_pkg::REW_W;
   logic [REW_W_L-1:0] rew;
   logic is_one;
   aad_pkg::aad_dec_t dn;

   // single copy only while the counter reads zero
   assign cp1 = a1[aad_pkg::CCPY_POS] | (a1[aad_pkg::SCPY_POS] & (c1 == '0));
   assign cp2 = a2[aad_pkg::CCPY_POS] | (a2[aad_pkg::SCPY_POS] & (c2 == '0));
   assign set1 = apply_set(a1, i_frm.base_set & i_frm.dmac_set, i_frm.base_set);
   // second lookup wins unless its low three bits are zero
   assign rew = (a2[aad_pkg::REW_POS +: 3] != 3'h0) ?
      a2[aad_pkg::REW_POS +: REW_W_L] : a1[aad_pkg::REW_POS +: REW_W_L];
   assign is_one = (rew[2:0] == aad_pkg::REW_ONE);

   always_comb begin
      dn = '0;
      dn.valid = i_frm.valid;
      dn.act1 = a1;
      dn.act2 = a2;
      dn.cpu_copy = cp1 | cp2;
      // queue of the second lookup takes precedence
      dn.cpu_queue = cp2 ? a2[aad_pkg::QSEL_POS +: aad_pkg::QSEL_W] :
         a1[aad_pkg::QSEL_POS +: aad_pkg::QSEL_W];
      dn.mirror = a1[aad_pkg::MIRR_POS] | a2[aad_pkg::MIRR_POS];
      dn.mirror_set = dn.mirror ? mirr_reg : '0;
      dn.learn_dis = a1[aad_pkg::LRN_POS] | a2[aad_pkg::LRN_POS];
      // policing taken from the first lookup only
      dn.pol_en = a1[aad_pkg::POL_EN_POS];
      dn.pol_idx = a1[aad_pkg::POL_IDX_POS +: aad_pkg::POL_IDX_W];
      dn.pol_only = a1[aad_pkg::POL_ONLY_POS];
      dn.fwd_set = apply_set(a2, set1, i_frm.base_set);
      dn.cpu_fwd = i_frm.cpu_fwd;
      dn.rew_cmd = rew;
      dn.rew_swap = (rew[3:0] == aad_pkg::REW_SWAP);
      dn.one_step = is_one;
      dn.addsub = is_one & rew[7];
      dn.egr_dly = is_one & rew[5];
      // backplane ingress ports get no ingress delay adjustment
      dn.ingr_adj = (is_one && !i_frm.backplane) ? rew[4:3] : 2'h0;
      dn.two_step = (rew[2:0] == aad_pkg::REW_TWO);
      dn.ts_id = dn.two_step ? rew[8:3] : 6'h00;
      dn.origin = (rew[3:0] == aad_pkg::REW_ORIGIN);
   end

   // ---------------------------------------------
   // output stage
   // ---------------------------------------------
   // fields hold between frames; only valid pulses
   logic vld_reg;
   logic [AW-1:0] act1_reg;
   logic [AW-1:0] act2_reg;
   logic copy_reg;
   logic [aad_pkg::QSEL_W-1:0] queue_reg;
   logic [NP-1:0] fwd_reg;
   logic cpuf_reg;
   logic mir_reg;
   logic [NP-1:0] mset_reg;
   logic lrn_reg;
   logic pen_reg;
   logic [aad_pkg::POL_IDX_W-1:0] pidx_reg;
   logic ponly_reg;
   logic [REW_W_L-1:0] rcmd_reg;
   logic swap_reg;
   logic one_reg;
   logic addsub_reg;
   logic egr_reg;
   logic [1:0] ingr_reg;
   logic two_reg;
   logic [5:0] tsid_reg;
   logic orig_reg;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         vld_reg <= 1'b0;
      end else begin
         vld_reg <= dn.valid;
      end
   end

   // lookup vectors, cpu copy and forwarding
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         act1_reg <= '0;
         act2_reg <= '0;
         copy_reg <= 1'b0;
         queue_reg <= '0;
         fwd_reg <= '0;
         cpuf_reg <= 1'b0;
      end else if (i_frm.valid) begin
         act1_reg <= dn.act1;
         act2_reg <= dn.act2;
         copy_reg <= dn.cpu_copy;
         queue_reg <= dn.cpu_queue;
         fwd_reg <= dn.fwd_set;
         cpuf_reg <= dn.cpu_fwd;
      end
   end

   // mirror, learning and policer commands
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mir_reg <= 1'b0;
         mset_reg <= '0;
         lrn_reg <= 1'b0;
         pen_reg <= 1'b0;
         pidx_reg <= '0;
         ponly_reg <= 1'b0;
      end else if (i_frm.valid) begin
         mir_reg <= dn.mirror;
         mset_reg <= dn.mirror_set;
         lrn_reg <= dn.learn_dis;
         pen_reg <= dn.pol_en;
         pidx_reg <= dn.pol_idx;
         ponly_reg <= dn.pol_only;
      end
   end

   // rewriter commands
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rcmd_reg <= '0;
         swap_reg <= 1'b0;
         one_reg <= 1'b0;
         addsub_reg <= 1'b0;
         egr_reg <= 1'b0;
         ingr_reg <= 2'h0;
         two_reg <= 1'b0;
         tsid_reg <= 6'h00;
         orig_reg <= 1'b0;
      end else if (i_frm.valid) begin
         rcmd_reg <= dn.rew_cmd;
         swap_reg <= dn.rew_swap;
         one_reg <= dn.one_step;
         addsub_reg <= dn.addsub;
         egr_reg <= dn.egr_dly;
         ingr_reg <= dn.ingr_adj;
         two_reg <= dn.two_step;
         tsid_reg <= dn.ts_id;
         orig_reg <= dn.origin;
      end
   end

   assign o_pready = pready_reg;
   assign o_prdata = prdata_reg;
   assign o_pslverr = pslverr_reg;
   // pure wiring of the flops, in the carrier's field order
   assign o_dec = {vld_reg, act1_reg, act2_reg, copy_reg, queue_reg, mir_reg, mset_reg,
      lrn_reg, pen_reg, pidx_reg, ponly_reg, fwd_reg, cpuf_reg, rcmd_reg, swap_reg,
      one_reg, addsub_reg, egr_reg, ingr_reg, two_reg, tsid_reg, orig_reg};
endmodule

// file: common/aad_pkg.sv
/*
 aad_pkg: constants and carriers for the classifier action decoder.
 assumes: one core clock; the lookup engine and analyzer share it.
*/
package aad_pkg;
   // ---------------------------------------------
   // sizes
   // ---------------------------------------------
   localparam int PORTS = 11;
   localparam int ENTRIES = 16;
   localparam int NACT = ENTRIES + PORTS + 1;
   localparam int IDX_W = 5;
   localparam int PORT_W = 4;
   localparam int ACT_W = 51;
   localparam int CNT_W = 32;
   // ---------------------------------------------
   // action vector fields
   // ---------------------------------------------
   localparam int SCPY_POS = 0;
   localparam int CCPY_POS = 1;
   localparam int QSEL_POS = 2;
   localparam int QSEL_W = 3;
   localparam int MODE_POS = 5;
   localparam int MODE_W = 2;
   localparam int MIRR_POS = 7;
   localparam int LRN_POS = 8;
   localparam int POL_EN_POS = 9;
   localparam int POL_IDX_POS = 10;
   localparam int POL_IDX_W = 11;
   localparam int POL_ONLY_POS = 21;
   localparam int PSET_POS = 22;
   localparam int REW_POS = 33;
   localparam int REW_W = 9;
   localparam int CNT_POS = 51;
   // ---------------------------------------------
   // rewrite command codes
   // ---------------------------------------------
   localparam logic [3:0] REW_NOP = 4'h0;
   localparam logic [3:0] REW_SWAP = 4'h8;
   localparam logic [3:0] REW_ORIGIN = 4'h9;
   localparam logic [2:0] REW_ONE = 3'h2;
   localparam logic [2:0] REW_TWO = 3'h3;
   // ---------------------------------------------
   // register offsets and resets
   // ---------------------------------------------
   localparam logic [11:0] OFS_SEL = 12'h000;
   localparam logic [11:0] OFS_LO = 12'h004;
   localparam logic [11:0] OFS_HI = 12'h008;
   localparam logic [11:0] OFS_CNT = 12'h00c;
   localparam logic [11:0] OFS_MIRR = 12'h010;
   localparam logic [ACT_W-1:0] ACT_RST = 51'h0;
   localparam logic [PORTS-1:0] MIRR_RST = 11'h000;

   typedef enum logic [1:0] {
      MM_NONE = 2'h0,
      MM_AND = 2'h1,
      MM_POLICY = 2'h2,
      MM_REDIR = 2'h3
   } aad_mode_t;

   typedef struct packed {
      logic valid;
      logic [PORT_W-1:0] port;
      logic backplane;
      logic hit1;
      logic [IDX_W-1:0] idx1;
      logic hit2;
      logic [IDX_W-1:0] idx2;
      logic [PORTS-1:0] base_set;
      logic [PORTS-1:0] dmac_set;
      logic cpu_fwd;
   } aad_frame_t;

   typedef struct packed {
      logic valid;
      logic [ACT_W-1:0] act1;
      logic [ACT_W-1:0] act2;
      logic cpu_copy;
      logic [QSEL_W-1:0] cpu_queue;
      logic mirror;
      logic [PORTS-1:0] mirror_set;
      logic learn_dis;
      logic pol_en;
      logic [POL_IDX_W-1:0] pol_idx;
      logic pol_only;
      logic [PORTS-1:0] fwd_set;
      logic cpu_fwd;
      logic [REW_W-1:0] rew_cmd;
      logic rew_swap;
      logic one_step;
      logic addsub;
      logic egr_dly;
      logic [1:0] ingr_adj;
      logic two_step;
      logic [5:0] ts_id;
      logic origin;
   } aad_dec_t;
endpackage

// file: tb/aad_decoder_asserts.sv
/* aad_decoder_asserts: checks between frame requests and decodes.
 assumes: bound into aad_decoder, sees its ports only. */
module aad_decoder_asserts #(
   parameter int ENTRIES = aad_pkg::ENTRIES
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // frames in, decodes out
   input wire aad_pkg::aad_frame_t i_frm,
   input wire aad_pkg::aad_dec_t o_dec
);
   timeunit 1ns;
   timeprecision 1ps;
   // raw vectors ride along, so fields are tied to them
   wire logic [50:0] a1 = o_dec.act1;
   wire logic [50:0] a2 = o_dec.act2;
   wire logic [8:0] w = o_dec.rew_cmd;
   wire logic v = o_dec.valid;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);
   property p_val; i_frm.valid |=> v; endproperty
   a_val: assert property (p_val) else $error("frame without decode");
   property p_cpu; i_frm.valid |=> o_dec.cpu_fwd == $past(i_frm.cpu_fwd); endproperty
   a_cpu: assert property (p_cpu) else $error("cpu port changed");
   property p_cpy; v && (a1[1] || a2[1]) |-> o_dec.cpu_copy; endproperty
   a_cpy: assert property (p_cpy) else $error("copy missing");
   property p_mir; v |-> {o_dec.mirror, o_dec.learn_dis} == {a1[7] | a2[7], a1[8] | a2[8]};
   endproperty
   a_mir: assert property (p_mir) else $error("mirror or learn wrong");
   property p_pol; v |-> {o_dec.pol_only, o_dec.pol_idx, o_dec.pol_en} == a1[21:9]; endproperty
   a_pol: assert property (p_pol) else $error("policer fields wrong");
   property p_rew; v |-> w == (a2[35:33] != 3'h0 ? a2[41:33] : a1[41:33]); endproperty
   a_rew: assert property (p_rew) else $error("rewrite command wrong");
   property p_swp; v |-> o_dec.rew_swap == (w[3:0] == 4'h8) && o_dec.origin == (w[3:0] == 4'h9);
   endproperty
   a_swp: assert property (p_swp) else $error("swap or origin wrong");
   property p_one; v |-> o_dec.one_step == (w[2:0] == 3'h2); endproperty
   a_one: assert property (p_one) else $error("one-step wrong");
   property p_two; v && w[2:0] == 3'h3 |-> o_dec.two_step && o_dec.ts_id == w[8:3]; endproperty
   a_two: assert property (p_two) else $error("two-step wrong");
endmodule
bind aad_decoder aad_decoder_asserts #(.ENTRIES(ENTRIES)) u_chk (.i_clk(i_clk),
   .i_arst_n(i_arst_n), .i_frm(i_frm), .o_dec(o_dec));

// file: tb/aad_far_sink.sv
/* aad_far_sink: analyzer and rewriter side, takes every decode.
 assumes: decodes arrive on the core clock with a one-cycle valid. */
module aad_far_sink (
   // clock
   input wire logic i_clk,
   // decoded commands
   input wire aad_pkg::aad_dec_t i_dec,
   // tally
   output int o_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // no back-pressure: the analyzer path cannot stall a decode
   always @(posedge i_clk)
      if (i_dec.valid === 1'b1)
         o_n <= o_n + 1;
endmodule

// file: tb/testbench.sv
/* testbench: random actions and frames against a queue model.
 assumes: package, decoder, checker and sink compiled before. */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, prdy, perr, e;
   logic [11:0] paddr = '0;
   logic [31:0] pwd = '0, prd, r;
   logic [10:0] mreg;
   logic [50:0] act[28];
   int unsigned cnt[28];
   int err_total = 0, n_compared = 0, n_seen;
   aad_pkg::aad_frame_t frm = '0;
   aad_pkg::aad_dec_t dec, y, q[$];
   always #4 clk = ~clk;
   aad_decoder u_dut (.i_clk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_pready(prdy), .o_prdata(prd),
      .o_pslverr(perr), .i_frm(frm), .o_dec(dec));
   aad_far_sink u_far (.i_clk(clk), .i_dec(dec), .o_n(n_seen));
   task automatic chk(input string s, input logic [127:0] x, g);
      n_compared++;
      if (x !== g) begin
         err_total++;
         $display("BAD %s exp %h got %h", s, x, g);
      end
   endtask
   task automatic finish_test();
      if (err_total == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (prdy !== 1'b1 && n < 50);
      r = prd;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 50) begin
         err_total++;
         finish_test();
      end
      @(posedge clk);
   endtask
   // policer index and rewrite kept to what software may legally write
   function automatic logic [50:0] mk();
      logic [50:0] a;
      a = 51'({$urandom, $urandom});
      a[20:10] = 11'(128 + $urandom % 64);
      case ($urandom % 5)
         0: a[41:33] = 9'h8;
         1: a[41:33] = 9'h9;
         2: a[41:33] = 9'(3 + 8 * ($urandom % 64));
         3: a[41:33] = 9'(2 + 8 * ($urandom % 3) + ($urandom & 32'ha0));
         default: a[41:33] = 9'h0;
      endcase
      return a;
   endfunction
   function automatic logic [10:0] ps(logic [50:0] a, logic [10:0] c, b);
      case (a[6:5])
         2'h1: return c & a[32:22];
         2'h2: return b & a[32:22];
         2'h3: return a[32:22];
         default: return c;
      endcase
   endfunction
   task automatic frame();
      aad_pkg::aad_frame_t f;
      aad_pkg::aad_dec_t x;
      logic [50:0] a, b;
      logic [8:0] w;
      logic c1, c2;
      int i, j;
      f = $bits(f)'({$urandom, $urandom});
      f.valid = 1'b1;
      f.port = 4'($urandom % 11);
      f.idx1[4] = 1'b0;
      f.idx2[4] = 1'b0;
      i = f.hit1 ? int'(f.idx1) : 16 + f.port;
      j = f.hit2 ? int'(f.idx2) : 27;
      a = act[i];
      b = act[j];
      c1 = a[1] | (a[0] & cnt[i] == 0);
      c2 = b[1] | (b[0] & cnt[j] == 0);
      w = b[35:33] != 3'h0 ? b[41:33] : a[41:33];
      x = '0;
      x.act1 = a;
      x.act2 = b;
      x.cpu_copy = c1 | c2;
      x.cpu_queue = c2 ? b[4:2] : a[4:2];
      x.fwd_set = ps(b, ps(a, f.base_set & f.dmac_set, f.base_set), f.base_set);
      x.cpu_fwd = f.cpu_fwd;
      x.mirror_set = a[7] | b[7] ? mreg : '0;
      x.ingr_adj = w[2:0] == 3'h2 && !f.backplane ? w[4:3] : 2'h0;
      x.egr_dly = w[2:0] == 3'h2 && w[5];
      x.addsub = w[2:0] == 3'h2 && w[7];
      cnt[i]++;
      cnt[j]++;
      q.push_back(x);
      frm <= f;
      @(posedge clk);
   endtask
   always @(posedge clk)
      if (dec.valid === 1'b1 && q.size() > 0) begin
         y = q.pop_front();
         chk("acts", {y.act1, y.act2}, {dec.act1, dec.act2});
         chk("cpu", {y.cpu_copy, y.cpu_queue}, {dec.cpu_copy, dec.cpu_queue});
         chk("fwd", {y.fwd_set, y.cpu_fwd}, {dec.fwd_set, dec.cpu_fwd});
         chk("mset", y.mirror_set, dec.mirror_set);
         chk("ptp", {y.ingr_adj, y.egr_dly, y.addsub},
            {dec.ingr_adj, dec.egr_dly, dec.addsub});
      end
   initial begin
      void'($urandom(32'h4830));
      mreg = 11'($urandom);
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(1'b1, aad_pkg::OFS_MIRR, 32'(mreg));
      for (int i = 0; i < 28; i++) begin
         act[i] = mk();
         apb(1'b1, aad_pkg::OFS_SEL, 32'(i));
         apb(1'b1, aad_pkg::OFS_LO, act[i][31:0]);
         apb(1'b1, aad_pkg::OFS_HI, 32'(act[i][50:32]));
      end
      // second pass after clearing re-arms single copies
      repeat (2) begin
         repeat (300) frame();
         frm <= '0;
         for (int i = 0; i < 28; i++) begin
            apb(1'b1, aad_pkg::OFS_SEL, 32'(i));
            apb(1'b0, aad_pkg::OFS_CNT, '0);
            chk("cnt", cnt[i], r);
            apb(1'b1, aad_pkg::OFS_CNT, '0);
            cnt[i] = 0;
         end
      end
      apb(1'b0, 12'h020, '0);
      chk("unmapped", 33'h1_0000_0000, {e, r});
      chk("seen", 600, n_seen);
      chk("left", 0, q.size());
      finish_test();
   end
endmodule
